//--- design/dlp_port.sv
// C-bit data link pin port: external serial mode or internal HDLC flag mode
`timescale 1ns/1ps
`default_nettype none
module dlp_port
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	// Register port
	input wire logic [dlp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dlp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dlp_pkg::DATA_W-1:0] reg_rdata,
	// Framer side (overhead domain)
	input wire logic rx_overhead_clock,
	input wire logic rx_oh_data,
	input wire logic rx_dl_slot,
	input wire logic tx_overhead_clock,
	input wire logic tx_dl_slot,
	output logic tx_dl_bit,
	output logic tx_dl_bit_valid,
	// Internal HDLC side (same clock)
	input wire logic rx_last_byte_read,
	input wire logic rx_overflow,
	input wire logic rx_status_event,
	input wire logic tx_underrun_event,
	input wire logic tx_last_byte_written,
	input wire logic tx_pending,
	input wire logic tx_mend_taken,
	output logic message_end_flag,
	output logic tx_data_wr,
	output logic [dlp_pkg::DATA_W-1:0] tx_data,
	// Pins
	output logic rx_link_serial_out,
	output logic rx_link_serial_out_oe,
	output logic rx_link_bit_clock,
	output logic rx_link_bit_clock_oe,
	input wire logic tx_link_serial_in,
	output logic tx_link_underrun,
	output logic tx_link_underrun_oe,
	output logic tx_link_bit_clock,
	output logic tx_link_bit_clock_oe,
	input wire logic tx_link_msg_end_in
);
	import dlp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic rx_oh_s1;
		logic rx_oh_s2;
		logic rx_oh_d;
		logic rx_dat_s1;
		logic rx_dat_s2;
		logic rx_slot_s1;
		logic rx_slot_s2;
		logic tx_oh_s1;
		logic tx_oh_s2;
		logic tx_oh_d;
		logic tx_slot_s1;
		logic tx_slot_s2;
		logic tx_sin_s1;
		logic tx_sin_s2;
		logic mendi_s1;
		logic mendi_s2;
		logic mendi_d;
		logic [CFG_W-1:0] cfg;
		logic cfg_written;
		logic rx_bit_pend;
		logic rx_bit;
		logic rx_ser;
		logic rx_bclk_low;
		logic [5:0] rx_low_cnt;
		logic [1:0] rx_oh_cnt;
		logic tx_bclk_low;
		logic [5:0] tx_low_cnt;
		logic [1:0] tx_oh_cnt;
		logic rx_mend_sticky;
		logic rx_mend_pin;
		logic rx_irq_sticky;
		logic rx_irq_pin;
		logic tx_udr;
		logic tx_irq;
		logic tx_mend;
		logic [DATA_W-1:0] rdata;
		logic tx_dl_bit;
		logic tx_dl_valid;
		logic tx_data_wr;
		logic [DATA_W-1:0] tx_data;
		logic rx_ser_o;
		logic rx_ser_oe;
		logic rx_clk_o;
		logic rx_clk_oe;
		logic tx_udr_oe;
		logic tx_clk_o;
		logic tx_clk_oe;
	} dlp_state_t;

	dlp_state_t st;
	dlp_state_t next_st;

	logic rxf;
	logic rxr;
	logic txf;
	logic mendi_rise;
	logic rd_irq;
	logic wr_cfg;
	logic wr_tx_cfg;
	logic wr_tx_stat;
	logic wr_tx_data;
	logic rx_mend_set;
	logic rx_irq_set;
	logic tx_udr_set;
	logic tx_irq_set;

	// Edges found on the synchronised overhead clocks
	assign rxf = st.rx_oh_d & ~st.rx_oh_s2;
	assign rxr = ~st.rx_oh_d & st.rx_oh_s2;
	assign txf = st.tx_oh_d & ~st.tx_oh_s2;
	assign mendi_rise = ~st.mendi_d & st.mendi_s2;
	assign rd_irq = reg_rd & (reg_addr == REG_IRQ_STAT);
	assign wr_cfg = reg_wr & (reg_addr == REG_CFG);
	assign wr_tx_cfg = reg_wr & (reg_addr == REG_TX_CFG);
	assign wr_tx_stat = reg_wr & (reg_addr == REG_TX_STAT);
	assign wr_tx_data = reg_wr & (reg_addr == REG_TX_DATA);
	assign rx_mend_set = rx_last_byte_read | rx_overflow;
	assign rx_irq_set = rx_status_event;
	assign tx_udr_set = tx_underrun_event;
	assign tx_irq_set = tx_last_byte_written & ~st.cfg[CFG_TX_EXT];

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_st = st;
		next_st.rx_oh_s1 = rx_overhead_clock;
		next_st.rx_oh_s2 = st.rx_oh_s1;
		next_st.rx_oh_d = st.rx_oh_s2;
		next_st.rx_dat_s1 = rx_oh_data;
		next_st.rx_dat_s2 = st.rx_dat_s1;
		next_st.rx_slot_s1 = rx_dl_slot;
		next_st.rx_slot_s2 = st.rx_slot_s1;
		next_st.tx_oh_s1 = tx_overhead_clock;
		next_st.tx_oh_s2 = st.tx_oh_s1;
		next_st.tx_oh_d = st.tx_oh_s2;
		next_st.tx_slot_s1 = tx_dl_slot;
		next_st.tx_slot_s2 = st.tx_slot_s1;
		next_st.tx_sin_s1 = tx_link_serial_in;
		next_st.tx_sin_s2 = st.tx_sin_s1;
		next_st.mendi_s1 = tx_link_msg_end_in;
		next_st.mendi_s2 = st.mendi_s1;
		next_st.mendi_d = st.mendi_s2;
		next_st.tx_dl_valid = 1'b0;
		next_st.tx_data_wr = 1'b0;

		// select bits written by software only
		if (wr_cfg)
		begin
			next_st.cfg = reg_wdata[CFG_W-1:0];
			next_st.cfg_written = 1'b1;
		end

		// capture data-link C-bits while the overhead bit is stable
		if (rxr && st.rx_slot_s2 && st.cfg[CFG_CBIT])
		begin
			next_st.rx_bit_pend = 1'b1;
			next_st.rx_bit = st.rx_dat_s2;
		end
		if (st.rx_bclk_low && st.rx_low_cnt != 6'h3F)
			next_st.rx_low_cnt = st.rx_low_cnt + 6'h01;
		// receive bit clock runs on falling overhead edges
		if (rxf)
		begin
			if (st.rx_bit_pend)
			begin
				next_st.rx_bclk_low = 1'b1;
				next_st.rx_ser = st.rx_bit;
				next_st.rx_bit_pend = 1'b0;
				next_st.rx_low_cnt = 6'h00;
				next_st.rx_oh_cnt = 2'h0;
			end
			else if (st.rx_bclk_low)
			begin
				next_st.rx_oh_cnt = st.rx_oh_cnt + 2'h1;
				if (st.rx_oh_cnt >= LOW_OH_EDGES - 2'h1 && st.rx_low_cnt >= MIN_LOW_CYC)
					next_st.rx_bclk_low = 1'b0;
			end
		end

		if (st.tx_bclk_low && st.tx_low_cnt != 6'h3F)
			next_st.tx_low_cnt = st.tx_low_cnt + 6'h01;
		// transmit bit clock changes on falling overhead edges only
		if (txf)
		begin
			if (st.tx_slot_s2)
			begin
				next_st.tx_bclk_low = 1'b1;
				next_st.tx_low_cnt = 6'h00;
				next_st.tx_oh_cnt = 2'h0;
			end
			else if (st.tx_bclk_low)
			begin
				next_st.tx_oh_cnt = st.tx_oh_cnt + 2'h1;
				// low time held for the minimum
				if (st.tx_oh_cnt >= LOW_OH_EDGES - 2'h1 && st.tx_low_cnt >= MIN_LOW_CYC)
				begin
					next_st.tx_bclk_low = 1'b0;
					// sample at the rising bit clock edge
					if (st.cfg[CFG_TX_EXT] && st.cfg[CFG_CBIT])
					begin
						next_st.tx_dl_bit = st.tx_sin_s2;
						next_st.tx_dl_valid = 1'b1;
					end
				end
			end
		end

		// status read clears, a new event wins
		if (rd_irq)
		begin
			next_st.rx_mend_sticky = 1'b0;
			next_st.rx_irq_sticky = 1'b0;
		end
		if (rx_mend_set)
			next_st.rx_mend_sticky = 1'b1;
		if (rx_irq_set)
			next_st.rx_irq_sticky = 1'b1;
		// flag pins follow the sticky bits on falling overhead edges
		if (rxf)
		begin
			next_st.rx_mend_pin = next_st.rx_mend_sticky;
			next_st.rx_irq_pin = next_st.rx_irq_sticky;
		end

		if (wr_tx_stat)
			next_st.tx_udr = 1'b0;
		if (tx_udr_set)
			next_st.tx_udr = 1'b1;
		if (wr_tx_cfg || wr_tx_data)
			next_st.tx_irq = 1'b0;
		if (tx_irq_set)
			next_st.tx_irq = 1'b1;
		if (wr_tx_data)
		begin
			next_st.tx_data_wr = 1'b1;
			next_st.tx_data = reg_wdata;
		end
		if (tx_mend_taken)
			next_st.tx_mend = 1'b0;
		if (wr_tx_cfg)
			next_st.tx_mend = reg_wdata[TXC_MEND];
		// pin sets the end flag only while data is pending
		if (mendi_rise && tx_pending)
			next_st.tx_mend = 1'b1;

		// Read data, one cycle after the strobe
		next_st.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				REG_CFG: next_st.rdata = DATA_W'(st.cfg);
				REG_IRQ_STAT:
				begin
					next_st.rdata[ST_RX_MEND] = st.rx_mend_sticky;
					next_st.rdata[ST_RX_IRQ] = st.rx_irq_sticky;
				end
				REG_TX_CFG: next_st.rdata[TXC_MEND] = st.tx_mend;
				REG_TX_STAT:
				begin
					next_st.rdata[ST_TX_UDR] = st.tx_udr;
					next_st.rdata[ST_TX_IRQ] = st.tx_irq;
				end
				default: next_st.rdata = '0;
			endcase
		end

		// Pin functions; active-low flags pull low when set, active-high flags pull low while clear
		// receive serial / message-end pin
		next_st.rx_ser_o = 1'b0;
		next_st.rx_clk_o = 1'b0;
		next_st.tx_clk_o = 1'b0;
		if (next_st.cfg[CFG_RX_EXT])
		begin
			next_st.rx_ser_o = next_st.rx_ser;
			next_st.rx_ser_oe = 1'b1;
			next_st.rx_clk_o = ~next_st.rx_bclk_low;
			next_st.rx_clk_oe = 1'b1;
		end
		else
		begin
			next_st.rx_ser_oe = next_st.rx_mend_pin ^ next_st.cfg[CFG_RX_MEND_POL];
			next_st.rx_clk_oe = next_st.rx_irq_pin ^ next_st.cfg[CFG_RX_IRQ_POL];
		end
		// transmit serial pin is input until selected otherwise
		if (!next_st.cfg_written || next_st.cfg[CFG_TX_EXT])
			next_st.tx_udr_oe = 1'b0;
		else
			next_st.tx_udr_oe = next_st.tx_udr ^ next_st.cfg[CFG_TX_UDR_POL];
		if (next_st.cfg_written && next_st.cfg[CFG_TX_EXT])
		begin
			next_st.tx_clk_o = ~next_st.tx_bclk_low;
			next_st.tx_clk_oe = 1'b1;
		end
		else
			next_st.tx_clk_oe = next_st.tx_irq ^ next_st.cfg[CFG_TX_IRQ_POL];
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			st <= '0;
		else if (ce)
			st <= next_st;
	end

	assign reg_rdata = st.rdata;
	assign tx_dl_bit = st.tx_dl_bit;
	assign tx_dl_bit_valid = st.tx_dl_valid;
	assign message_end_flag = st.tx_mend;
	assign tx_data_wr = st.tx_data_wr;
	assign tx_data = st.tx_data;
	assign rx_link_serial_out = st.rx_ser_o;
	assign rx_link_serial_out_oe = st.rx_ser_oe;
	assign rx_link_bit_clock = st.rx_clk_o;
	assign rx_link_bit_clock_oe = st.rx_clk_oe;
	assign tx_link_underrun = 1'b0 & st.tx_udr_oe;
	assign tx_link_underrun_oe = st.tx_udr_oe;
	assign tx_link_bit_clock = st.tx_clk_o;
	assign tx_link_bit_clock_oe = st.tx_clk_oe;

	////////////////////////////////////////////////////////////////////////////
	default clocking dlp_cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	rx_ser_edge_a: assert property ($changed(st.rx_ser) |-> $rose(st.rx_bclk_low))
		else $error("receive serial changed off the bit clock fall");
	rx_mend_edge_a: assert property ($changed(st.rx_mend_pin) |-> $past(rxf))
		else $error("message-end pin moved off a falling overhead edge");
	rx_mend_clear_a: assert property ($fell(st.rx_mend_sticky) |-> $past(rd_irq))
		else $error("message-end cleared without a status read");
	rx_mend_set_a: assert property (rx_mend_set && ce |=> st.rx_mend_sticky)
		else $error("message-end missed a last byte or overflow");
	rx_clk_edge_a: assert property ($changed(st.rx_bclk_low) |-> $past(rxf))
		else $error("receive bit clock moved off a falling overhead edge");
	rx_low_a: assert property ($fell(st.rx_bclk_low) |-> $past(st.rx_low_cnt) >= MIN_LOW_CYC)
		else $error("receive bit clock low too short");
	tx_udr_clear_a: assert property ($fell(st.tx_udr) |-> $past(wr_tx_stat))
		else $error("underrun cleared without a status write");
	tx_udr_set_a: assert property (tx_udr_set && ce |=> st.tx_udr)
		else $error("underrun event not latched");
	tx_low_a: assert property ($fell(st.tx_bclk_low) |-> $past(st.tx_low_cnt) >= MIN_LOW_CYC)
		else $error("transmit bit clock low too short");
	tx_clk_edge_a: assert property ($changed(st.tx_bclk_low) |-> $past(txf))
		else $error("transmit bit clock moved off a falling overhead edge");
	tx_ignore_a: assert property (st.tx_dl_valid |-> $past(&st.cfg[CFG_CBIT:CFG_TX_EXT]))
		else $error("transmit serial bit taken outside C-bit external mode");
	mend_pin_a: assert property ($rose(st.tx_mend) && !$past(wr_tx_cfg) |-> $past(tx_pending))
		else $error("end flag set by pin with nothing pending");
	tx_reset_pin_a: assert property (!st.cfg_written |-> !st.tx_udr_oe)
		else $error("transmit serial pin driven before selection");
	rx_ext_a: assert property (st.cfg[CFG_RX_EXT] |-> st.rx_ser_oe && st.rx_ser_o == st.rx_ser)
		else $error("receive serial pin not presenting the stream");
	tx_irq_set_a: assert property (tx_irq_set && !st.tx_irq && ce |=> st.tx_irq)
		else $error("transmit interrupt missed the last byte");
endmodule // dlp_port
`default_nettype wire

//--- design/dlp_pkg.sv
// Constants for the C-bit data link pin port
//
// Contract
// - Receive external select 1 drives the extracted link stream on the serial output.
// - In C-bit parity mode the serial output carries the three subframe-5 C-bits.
// - Receive serial output changes only on falling edges of the receive bit clock.
// - Receive external select 0 turns the shared pin into the message-end flag.
// - Message-end flag asserts on last byte read or receive buffer overflow.
// - Message-end flag pin updates only on falling receive overhead clock edges.
// - Reading the interrupt enable/status register is the only way to clear message-end.
// - Transmit external select 1 takes subframe-5 C-bits from the serial input.
// - Without C-bit parity mode the transmit serial input is ignored.
// - External controller keeps transmit serial input valid at the bit clock rise.
// - Transmit external select 0 makes the shared pin the underrun flag.
// - Writing the transmit interrupt status register clears the underrun flag.
// - Underrun and transmit interrupt are open-drain with selectable polarity.
// - After reset serial pin is input, clock pin is interrupt, until select written.
// - Transmit bit clock is about 28.2 kHz and low at least 1.9 us.
// - Transmit bit clock changes on falling overhead edges, three cycles per M-frame.
// - In internal mode the transmit interrupt asserts after the last queued byte.
// - After transmit interrupt, config write ends message, data write continues it.
// - Message-end input sets the end flag, same as software setting it.
// - Message-end input is ignored when no transmission is pending.
// - Receive bit clock like transmit: 28.2 kHz, low 1.9 us, three per M-frame.
// - In internal mode receive clock pin is the interrupt, cleared by status read.
package dlp_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [ADDR_W-1:0] REG_CFG = 3'h0;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 3'h1;
	localparam logic [ADDR_W-1:0] REG_TX_CFG = 3'h2;
	localparam logic [ADDR_W-1:0] REG_TX_STAT = 3'h3;
	localparam logic [ADDR_W-1:0] REG_TX_DATA = 3'h4;
	// Configuration register fields
	localparam int CFG_W = 7;
	localparam int CFG_RX_EXT = 0;
	localparam int CFG_TX_EXT = 1;
	localparam int CFG_CBIT = 2;
	localparam int CFG_RX_MEND_POL = 3;
	localparam int CFG_RX_IRQ_POL = 4;
	localparam int CFG_TX_UDR_POL = 5;
	localparam int CFG_TX_IRQ_POL = 6;
	localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
	// Status fields
	localparam int ST_RX_MEND = 0;
	localparam int ST_RX_IRQ = 1;
	localparam int ST_TX_UDR = 0;
	localparam int ST_TX_IRQ = 1;
	localparam int TXC_MEND = 0;
	// Bit clock timing
	localparam int CLK_NS = 50;
	localparam int BIT_CLK_HZ = 28200;
	localparam int MIN_LOW_NS = 1900;
	localparam int MIN_LOW_CYC_I = (MIN_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0] MIN_LOW_CYC = 6'(MIN_LOW_CYC_I);
	localparam logic [1:0] LOW_OH_EDGES = 2'h2;
	localparam int MEND_WINDOW_US = 210;
endpackage : dlp_pkg

//--- sim/dlp_far_end.sv
// Far-end HDLC controller model on the serial data link pins
`timescale 1ns/1ps
`default_nettype none
module dlp_far_end
(
	input wire logic tx_link_bit_clock,
	output logic tx_link_serial_in,
	output logic tx_link_msg_end_in,
	input wire logic rx_link_bit_clock,
	input wire logic rx_link_serial_out
);
	int seed = 63917;
	logic tx_q[$];
	logic rx_q[$];

	////////////////////////////////////////////////////////////////
	initial
	begin
		tx_link_serial_in = 1'b0;
		tx_link_msg_end_in = 1'b0;
	end

	always @(negedge tx_link_bit_clock)
	begin
		tx_link_serial_in = 1'($random(seed));
		tx_q.push_back(tx_link_serial_in);
	end

	always @(posedge tx_link_bit_clock)
	begin
		#200;
		tx_link_serial_in = ~tx_link_serial_in;
	end

	always @(posedge rx_link_bit_clock)
		rx_q.push_back(rx_link_serial_out);

	////////////////////////////////////////////////////////////////
	// prompt end pulse
	task automatic send_msg_end();
		tx_link_msg_end_in = 1'b1;
		#500;
		tx_link_msg_end_in = 1'b0;
	endtask
endmodule // dlp_far_end
`default_nettype wire

//--- sim/testbench.sv
// Self-checking testbench for the data link pin port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dlp_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata, tx_data, d, wd;
	logic rx_oh = 1'b0;
	logic tx_oh = 1'b0;
	logic rx_bit = 1'b0;
	logic rx_slot = 1'b0;
	logic tx_slot = 1'b0;
	logic [5:0] ev = '0;
	logic tx_pending = 1'b0;
	logic tx_dl_bit, tx_dl_bit_valid, message_end_flag, tx_data_wr, nb, rbc_q, rso_q;
	logic rx_link_serial_out, rx_link_serial_out_oe, rx_link_bit_clock, rx_link_bit_clock_oe;
	logic tx_link_serial_in, tx_link_underrun, tx_link_underrun_oe, tx_link_bit_clock;
	logic tx_link_bit_clock_oe, tx_link_msg_end_in;
	int seed = 63917;
	int checks_done, fail_count, rk, tk, tx_slots, tx_rises, rlow, tlow, valid_cnt, dcnt;
	bit slot_en, trk;
	logic rx_exp[$];

	dlp_port uut
	(
		.ref_clk, .resetn, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_overhead_clock(rx_oh), .rx_oh_data(rx_bit), .rx_dl_slot(rx_slot),
		.tx_overhead_clock(tx_oh), .tx_dl_slot(tx_slot), .tx_dl_bit, .tx_dl_bit_valid,
		.rx_last_byte_read(ev[0]), .rx_overflow(ev[1]), .rx_status_event(ev[2]),
		.tx_underrun_event(ev[3]), .tx_last_byte_written(ev[4]), .tx_pending,
		.tx_mend_taken(ev[5]), .message_end_flag, .tx_data_wr, .tx_data,
		.rx_link_serial_out, .rx_link_serial_out_oe, .rx_link_bit_clock,
		.rx_link_bit_clock_oe, .tx_link_serial_in, .tx_link_underrun, .tx_link_underrun_oe,
		.tx_link_bit_clock, .tx_link_bit_clock_oe, .tx_link_msg_end_in
	);

	dlp_far_end far
	(
		.tx_link_bit_clock, .tx_link_serial_in, .tx_link_msg_end_in,
		.rx_link_bit_clock, .rx_link_serial_out
	);

	////////////////////////////////////////////////////////////////
	always #25 ref_clk = ~ref_clk;
	initial #37 forever #200 rx_oh = ~rx_oh;
	initial #111 forever #200 tx_oh = ~tx_oh;

	// One data link bit every eighth overhead bit
	always @(negedge rx_oh)
	begin
		rk = (rk + 1) % 8;
		nb = 1'($random(seed));
		rx_bit <= nb;
		rx_slot <= slot_en && rk == 0;
		if (slot_en && rk == 0 && trk)
			rx_exp.push_back(nb);
	end

	always @(posedge tx_oh)
	begin
		tk = (tk + 1) % 8;
		tx_slot <= slot_en && tk == 0;
		if (slot_en && tk == 0)
			tx_slots++;
	end

	////////////////////////////////////////////////////////////////
	always @(posedge ref_clk)
	begin
		if (tx_data_wr === 1'b1)
		begin
			dcnt++;
			check(tx_data, wd);
		end
		if (tx_dl_bit_valid === 1'b1)
		begin
			valid_cnt++;
			if (trk)
				check(tx_dl_bit, far.tx_q.size() ? far.tx_q.pop_front() : 1'bx);
		end
		if (rx_exp.size() && far.rx_q.size())
			check(far.rx_q.pop_front(), rx_exp.pop_front());
		if (trk && rbc_q === 1'b1 && rx_link_bit_clock === 1'b1)
			check(rx_link_serial_out, rso_q);
		rbc_q = rx_link_bit_clock;
		rso_q = rx_link_serial_out;
		if (tx_link_bit_clock === 1'b0)
			tlow++;
		else if (tlow)
		begin
			if (trk)
				check(tlow >= MIN_LOW_CYC_I, 1);
			tx_rises++;
			tlow = 0;
		end
		if (rx_link_bit_clock === 1'b0)
			rlow++;
		else if (rlow)
		begin
			if (trk)
				check(rlow >= MIN_LOW_CYC_I, 1);
			rlow = 0;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic settle();
		repeat (24) @(posedge ref_clk);
	endtask

	task automatic fire(input int i);
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		@(posedge ref_clk);
		ev <= '0;
		settle();
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(REG_CFG);
		check(d, 8'h00);
		check({tx_link_underrun_oe, tx_link_bit_clock_oe}, 2'b00);
		wr(3'h7, 8'hFF);
		rd(3'h7);
		check(d, 8'h00);
		wr(REG_CFG, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			fire(i);
			check(rx_link_serial_out_oe, 1'b1);
			wr(REG_TX_STAT, 8'h00);
			settle();
			check(rx_link_serial_out_oe, 1'b1);
			rd(REG_IRQ_STAT);
			check(d[ST_RX_MEND], 1'b1);
			settle();
			check(rx_link_serial_out_oe, 1'b0);
		end
		fire(2);
		check(rx_link_bit_clock_oe, 1'b1);
		rd(REG_IRQ_STAT);
		check(d[ST_RX_IRQ], 1'b1);
		settle();
		check(rx_link_bit_clock_oe, 1'b0);
		fire(3);
		check(tx_link_underrun_oe, 1'b1);
		rd(REG_TX_STAT);
		check(d[ST_TX_UDR], 1'b1);
		wr(REG_TX_STAT, 8'h00);
		settle();
		check(tx_link_underrun_oe, 1'b0);
		// Active-high flags pull low while idle
		wr(REG_CFG, 8'h60);
		settle();
		check({tx_link_underrun_oe, tx_link_bit_clock_oe}, 2'b11);
		check(tx_link_underrun, 1'b0);
		fire(3);
		fire(4);
		check({tx_link_underrun_oe, tx_link_bit_clock_oe}, 2'b00);
		wr(REG_TX_STAT, 8'h00);
		wd = 8'($random(seed));
		wr(REG_TX_DATA, wd);
		settle();
		check({tx_link_underrun_oe, tx_link_bit_clock_oe}, 2'b11);
		check(dcnt == 1, 1);
		fire(4);
		wr(REG_TX_CFG, 8'h00);
		rd(REG_TX_STAT);
		check(d[ST_TX_IRQ], 1'b0);
		far.send_msg_end();
		settle();
		check(message_end_flag, 1'b0);
		tx_pending <= 1'b1;
		far.send_msg_end();
		settle();
		check(message_end_flag, 1'b1);
		fire(5);
		check(message_end_flag, 1'b0);
		wr(REG_TX_CFG, 8'h01);
		settle();
		check(message_end_flag, 1'b1);
		tx_pending <= 1'b0;
		// External serial mode with C-bit parity
		wr(REG_CFG, 8'h07);
		settle();
		far.tx_q.delete();
		far.rx_q.delete();
		{tx_slots, tx_rises, valid_cnt} = '0;
		{trk, slot_en} = 2'b11;
		repeat (1200) @(posedge ref_clk);
		slot_en = 1'b0;
		repeat (200) @(posedge ref_clk);
		trk = 1'b0;
		check(tx_slots > 10 && tx_rises == tx_slots, 1);
		check(valid_cnt == tx_slots, 1);
		check(rx_exp.size() + far.rx_q.size() == 0, 1);
		wr(REG_CFG, 8'h03);
		valid_cnt = 0;
		slot_en = 1'b1;
		repeat (600) @(posedge ref_clk);
		slot_en = 1'b0;
		repeat (200) @(posedge ref_clk);
		check(valid_cnt == 0, 1);
		results();
	end

	// Whole sequence needs about 2800 cycles
	initial
	begin
		#1000000;
		fail_count++;
		results();
	end
endmodule // testbench
`default_nettype wire
